// ==== acl_params.svh ====
`ifndef ACL_PARAMS_SVH
`define ACL_PARAMS_SVH
`define ACL_TAG_TOP 5'hF
`define ACL_SLOT_TOP 5'h13
`define ACL_LAST_SLOT 4'hC
`define ACL_SLOT_CMD 4'h1
`define ACL_SLOT_DAT 4'h2
`define ACL_SLOT_LEFT 4'h3
`define ACL_SLOT_RIGHT 4'h4
`define ACL_FRAME_VALID 15
`define ACL_CMD_RD 19
`define ACL_IDX_HI 18
`define ACL_IDX_LO 12
`define ACL_DAT_HI 19
`define ACL_DAT_LO 4
`define ACL_REC_BITS 18
`define ACL_REG_COUNT 64
`define ACL_REG_RESET 16'h0000
`define ACL_SYNC_HIGH_BITS 5'h10
`define ACL_CORE_KHZ 250000
`define ACL_BITCLK_KHZ 12288
`endif

// ==== acl_pkg.sv ====
`include "acl_params.svh"
package acl_pkg;
	// Frame position of the link
	typedef enum logic [2:0] {
		ACL_IDLE = 3'h1,
		ACL_TAG = 3'h2,
		ACL_DATA = 3'h4
	} acl_state_t;
	// One playback sample with its slot tag
	typedef struct packed {
		logic valid;
		logic [19:0] sample;
	} acl_pcm_t;
	// One record sample offered for the next frame
	typedef struct packed {
		logic valid;
		logic [17:0] sample;
	} acl_rec_t;
	// A register write taken from the link
	typedef struct packed {
		logic valid;
		logic [6:0] index;
		logic [15:0] data;
	} acl_cmd_t;
endpackage

// ==== acl_bitclk_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "acl_params.svh"
module acl_bitclk_gen #(
	parameter int CORE_KHZ = `ACL_CORE_KHZ,
	parameter int BIT_KHZ = `ACL_BITCLK_KHZ
) (
	input wire logic core_clk,
	input wire logic resetn,
	output logic bitClk,
	output logic riseEn,
	output logic fallEn
);
	localparam int ACC_W = $clog2(CORE_KHZ) + 1;
	localparam logic [ACC_W:0] STEP = (ACC_W + 1)'(2 * BIT_KHZ);
	localparam logic [ACC_W:0] MODULUS = (ACC_W + 1)'(CORE_KHZ);

	// Each bit needs a rising and a falling core cycle of its own
	if (4 * BIT_KHZ > CORE_KHZ) begin : g_bad_rate
		$error("bit clock too fast for core clock");
	end

	logic [ACC_W-1:0] acc;
	logic [ACC_W:0] sum;
	logic wrap;

	// Fractional divider: the ratio is not whole, so edges jitter one cycle
	assign sum = {1'b0, acc} + STEP;
	assign wrap = (sum >= MODULUS);

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			acc <= '0;
		end else if (wrap) begin
			acc <= ACC_W'(sum - MODULUS);
		end else begin
			acc <= sum[ACC_W-1:0];
		end
	end

	// Pin level and one-cycle edge enables move together
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			bitClk <= 1'b0;
			riseEn <= 1'b0;
			fallEn <= 1'b0;
		end else begin
			if (wrap) begin
				bitClk <= !bitClk;
			end
			riseEn <= wrap && !bitClk;
			fallEn <= wrap && bitClk;
		end
	end
endmodule
`default_nettype wire

// ==== acl_frame_serdes.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "acl_params.svh"
module acl_frame_serdes
	import acl_pkg::*;
#(
	parameter int CORE_KHZ = `ACL_CORE_KHZ,
	parameter int BIT_KHZ = `ACL_BITCLK_KHZ,
	parameter int REG_COUNT = `ACL_REG_COUNT
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic sync,
	input wire logic sdataOut,
	output logic bitClk,
	output logic sdataIn,
	input wire logic codecReady,
	input wire acl_rec_t recLeft,
	input wire acl_rec_t recRight,
	input wire logic [5:0] regLookup,
	output logic [15:0] regLookupData,
	output acl_cmd_t regWr,
	output acl_pcm_t playLeft,
	output acl_pcm_t playRight,
	output logic frameStart,
	output logic oddIndex,
	output logic syncFault
);
	// The index field addresses 64 even locations, no more
	if (REG_COUNT < 1 || REG_COUNT > `ACL_REG_COUNT) begin : g_bad_count
		$error("register count out of range");
	end

	// Record samples plus their two pad bits must fill one slot exactly
	if ($bits(acl_rec_t) != `ACL_REC_BITS + 1) begin : g_bad_rec
		$error("record sample width does not match the slot");
	end

	logic riseEn;
	logic fallEn;

	// Bit clock and its edge enables
	acl_bitclk_gen #(
		.CORE_KHZ(CORE_KHZ),
		.BIT_KHZ(BIT_KHZ)
	) u_bitclk (
		.core_clk(core_clk),
		.resetn(resetn),
		.bitClk(bitClk),
		.riseEn(riseEn),
		.fallEn(fallEn)
	);

	acl_state_t state;
	logic [3:0] slot;
	logic [4:0] bitIdx;
	logic syncPrev;
	logic syncRise;
	logic [18:0] rxShift;
	logic [19:0] rxWord;
	logic [15:0] rxTag;
	logic [19:0] rxCmd;
	logic slotEnd;
	logic [15:0] regs [REG_COUNT];
	logic [15:0] txTag;
	logic [19:0] txCmd;
	logic [19:0] txDat;
	logic [19:0] txLeft;
	logic [19:0] txRight;
	logic txBit;
	logic rdPending;
	logic [6:0] rdIndex;
	logic [15:0] rdData;
	logic cmdRead;
	logic [6:0] cmdIndex;
	logic cmdInRange;
	logic wrHit;
	logic rdHit;
	logic oddHit;
	logic [4:0] syncHigh;

	// Frame start is the falling-edge sample that first sees SYNC high
	assign syncRise = fallEn && sync && !syncPrev;

	// Full slot word once its last bit is on the pin
	assign rxWord = {rxShift, sdataOut};
	assign slotEnd = fallEn && !syncRise && (state != ACL_IDLE) && (bitIdx == 5'h00);

	// Command fields of slot 1, taken when slot 2 completes
	assign cmdRead = rxCmd[`ACL_CMD_RD];
	assign cmdIndex = rxCmd[`ACL_IDX_HI:`ACL_IDX_LO];
	assign cmdInRange = !cmdIndex[0] && (int'(cmdIndex[6:1]) < REG_COUNT);

	// Writes need frame, slot 1 and slot 2 tags; odd indexes are dropped
	always_comb begin
		wrHit = 1'b0;
		rdHit = 1'b0;
		if (slotEnd && slot == `ACL_SLOT_DAT && rxTag[`ACL_FRAME_VALID] && rxTag[14]) begin
			rdHit = cmdRead;
			wrHit = !cmdRead && rxTag[13] && cmdInRange;
		end
	end

	// Odd-index notice only for a command that the frame really carries
	assign oddHit = slotEnd && slot == `ACL_SLOT_DAT && rxTag[`ACL_FRAME_VALID] && rxTag[14]
		&& (cmdRead || rxTag[13]) && cmdIndex[0];

	// Position within the frame; advances after each falling-edge sample
	// A SYNC rise mid-frame restarts the count and drops the cut frame
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state <= ACL_IDLE;
			slot <= 4'h0;
			bitIdx <= 5'h00;
		end else if (syncRise) begin
			state <= ACL_TAG;
			slot <= 4'h0;
			bitIdx <= `ACL_TAG_TOP;
		end else if (fallEn) begin
			case (state)
				ACL_IDLE: begin
					slot <= 4'h0;
				end
				ACL_TAG, ACL_DATA: begin
					if (bitIdx != 5'h00) begin
						bitIdx <= bitIdx - 5'h01;
					end else if (slot == `ACL_LAST_SLOT) begin
						state <= ACL_IDLE;
					end else begin
						state <= ACL_DATA;
						slot <= slot + 4'h1;
						bitIdx <= `ACL_SLOT_TOP;
					end
				end
				default: begin
					state <= ACL_IDLE;
				end
			endcase
		end
	end

	// Previous SYNC sample, taken on falling edges only
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			syncPrev <= 1'b0;
		end else if (fallEn) begin
			syncPrev <= sync;
		end
	end

	// Tag-phase length check; a short or long SYNC flags a fault level
	// The level is kept until the next SYNC fall judges a new tag phase
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			syncHigh <= 5'h00;
			syncFault <= 1'b0;
		end else if (fallEn) begin
			if (sync && syncHigh != 5'h1F) begin
				syncHigh <= syncHigh + 5'h01;
			end else if (!sync) begin
				syncHigh <= 5'h00;
			end
			if (!sync && syncPrev) begin
				syncFault <= (syncHigh != `ACL_SYNC_HIGH_BITS);
			end
		end
	end

	// Outgoing bits shift in MSB first on the falling edge
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rxShift <= '0;
		end else if (syncRise) begin
			rxShift <= '0;
		end else if (fallEn && state != ACL_IDLE) begin
			rxShift <= rxWord[18:0];
		end
	end

	// Slot 0 tags and the slot 1 command are held for the frame
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rxTag <= 16'h0000;
			rxCmd <= 20'h00000;
		end else if (syncRise) begin
			rxTag <= 16'h0000;
		end else if (slotEnd && slot == 4'h0) begin
			rxTag <= rxWord[15:0];
		end else if (slotEnd && slot == `ACL_SLOT_CMD) begin
			rxCmd <= rxWord;
		end
	end

	// Playback samples; valid only when frame and slot tags are set
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			playLeft <= '0;
			playRight <= '0;
		end else begin
			playLeft.valid <= 1'b0;
			playRight.valid <= 1'b0;
			if (slotEnd && slot == `ACL_SLOT_LEFT) begin
				playLeft.sample <= rxWord;
				playLeft.valid <= rxTag[`ACL_FRAME_VALID] && rxTag[12];
			end
			if (slotEnd && slot == `ACL_SLOT_RIGHT) begin
				playRight.sample <= rxWord;
				playRight.valid <= rxTag[`ACL_FRAME_VALID] && rxTag[11];
			end
		end
	end

	// Register file; write data sits in slot 2 bits 19 to 4
	// Flip-flops keep lookups single-cycle; area grows with REG_COUNT
	for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
		always_ff @(posedge core_clk) begin
			if (!resetn) begin
				regs[i] <= `ACL_REG_RESET;
			end else if (wrHit && int'(cmdIndex[6:1]) == i) begin
				regs[i] <= rxWord[`ACL_DAT_HI:`ACL_DAT_LO];
			end
		end
	end

	// Write report and odd-index notice, one cycle each
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			regWr <= '0;
			oddIndex <= 1'b0;
		end else begin
			regWr.valid <= wrHit;
			oddIndex <= 1'b0;
			if (wrHit) begin
				regWr.index <= cmdIndex;
				regWr.data <= rxWord[`ACL_DAT_HI:`ACL_DAT_LO];
			end
			if (oddHit) begin
				oddIndex <= 1'b1;
			end
		end
	end

	// Local view of one register, for the mixer and power logic
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			regLookupData <= `ACL_REG_RESET;
		end else if (int'(regLookup) < REG_COUNT) begin
			regLookupData <= regs[regLookup];
		end else begin
			regLookupData <= 16'h0000;
		end
	end

	// A read is answered in the next frame; a late set wins over the clear
	// Only one read waits; a second read before the answer replaces it
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rdPending <= 1'b0;
			rdIndex <= 7'h00;
		end else begin
			if (syncRise) begin
				rdPending <= 1'b0;
			end
			if (rdHit) begin
				rdPending <= 1'b1;
				rdIndex <= cmdIndex;
			end
		end
	end

	// Odd or absent indexes read back as zero
	always_comb begin
		rdData = 16'h0000;
		if (!rdIndex[0] && int'(rdIndex[6:1]) < REG_COUNT) begin
			rdData = regs[rdIndex[6:1]];
		end
	end

	// Incoming frame contents frozen at frame start; untagged slots zero
	// Freezing keeps a slot from mixing halves of two samples
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			txTag <= 16'h0000;
			txCmd <= 20'h00000;
			txDat <= 20'h00000;
			txLeft <= 20'h00000;
			txRight <= 20'h00000;
		end else if (syncRise) begin
			txTag <= 16'h0000;
			txCmd <= 20'h00000;
			txDat <= 20'h00000;
			txLeft <= 20'h00000;
			txRight <= 20'h00000;
			txTag[`ACL_FRAME_VALID] <= codecReady;
			if (codecReady && rdPending) begin
				txTag[14] <= 1'b1;
				txTag[13] <= 1'b1;
				txCmd <= {1'b0, rdIndex, 12'h000};
				txDat <= {rdData, 4'h0};
			end
			if (codecReady && recLeft.valid) begin
				txTag[12] <= 1'b1;
				txLeft <= {recLeft.sample, 2'h0};
			end
			if (codecReady && recRight.valid) begin
				txTag[11] <= 1'b1;
				txRight <= {recRight.sample, 2'h0};
			end
		end
	end

	// Bit for the current position, MSB first; reserved slots give zero
	// Slot n is tagged by slot 0 bit 15-n
	always_comb begin
		txBit = 1'b0;
		case (slot)
			4'h0: txBit = txTag[bitIdx[3:0]];
			`ACL_SLOT_CMD: txBit = txCmd[bitIdx];
			`ACL_SLOT_DAT: txBit = txDat[bitIdx];
			`ACL_SLOT_LEFT: txBit = txLeft[bitIdx];
			`ACL_SLOT_RIGHT: txBit = txRight[bitIdx];
			default: txBit = 1'b0;
		endcase
	end

	// Incoming bits change on the rising edge, low outside frames
	// Registered, so the pin cannot glitch between rises
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			sdataIn <= 1'b0;
		end else if (riseEn) begin
			sdataIn <= (state != ACL_IDLE) ? txBit : 1'b0;
		end
	end

	// Frame start pulse, one core cycle
	// Lets local logic align to frames without watching the pins
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			frameStart <= 1'b0;
		end else begin
			frameStart <= syncRise;
		end
	end
endmodule
`default_nettype wire

// ==== acl_frame_serdes_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module acl_frame_serdes_assertions
	import acl_pkg::*;
#(
	parameter int REG_COUNT = 64
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic sync,
	input wire logic bitClk,
	input wire logic sdataIn,
	input wire logic codecReady,
	input wire acl_cmd_t regWr,
	input wire acl_pcm_t playLeft,
	input wire logic frameStart,
	input wire logic oddIndex
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	chk_frame_mark: assert property (
		frameStart |-> $past(sync) && !$past(bitClk) ##1 !frameStart [*8])
		else $error("bad frame start");
	chk_bit_launch: assert property (
		$changed(sdataIn) |-> $past(bitClk) && !$past(bitClk, 2))
		else $error("bit moved off a rise");
	chk_ready_bit: assert property (
		frameStart && codecReady |-> ##[4:16] sdataIn)
		else $error("ready bit missing");
	chk_quiet_unready: assert property (!codecReady |-> !sdataIn)
		else $error("data while not ready");
	chk_wr_once: assert property (
		regWr.valid |-> !sync ##1 !regWr.valid [*8])
		else $error("bad write pulse");
	chk_wr_even: assert property (
		regWr.valid |-> !regWr.index[0] && regWr.index[6:1] < REG_COUNT)
		else $error("write to invalid register");
	chk_odd_nowr: assert property (oddIndex |-> !regWr.valid ##1 !oddIndex)
		else $error("odd index written");
	chk_play_pulse: assert property (
		playLeft.valid |-> !sync ##1 !playLeft.valid)
		else $error("bad playback pulse");
endmodule

bind acl_frame_serdes acl_frame_serdes_assertions #(.REG_COUNT(REG_COUNT)) chk (
	.core_clk(core_clk), .resetn(resetn), .sync(sync), .bitClk(bitClk),
	.sdataIn(sdataIn), .codecReady(codecReady), .regWr(regWr),
	.playLeft(playLeft), .frameStart(frameStart), .oddIndex(oddIndex)
);
`default_nettype wire

// ==== acl_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module acl_ctrl_model (
	input wire logic core_clk,
	input wire logic bitClk,
	input wire logic sdataIn,
	input wire logic start,
	input wire logic [255:0] txFrame,
	output logic sync,
	output logic sdataOut,
	output logic busy,
	output logic [255:0] rxFrame
);
	logic prevClk = 1'b0;
	logic [8:0] pos = 9'h000;
	logic [255:0] txShift = '0;
	initial begin
		sync = 1'b0;
		sdataOut = 1'b0;
		busy = 1'b0;
		rxFrame = '0;
	end
	// Launch on the bit-clock rises of a frame, sample on the falls after data bits
	always @(posedge core_clk) begin
		prevClk <= bitClk;
		if (bitClk && !prevClk && (busy || start)) begin
			sync <= !busy || pos < 9'h010;
			sdataOut <= busy && txShift[255];
			txShift <= busy ? txShift << 1 : txFrame;
			pos <= busy ? pos + 9'h001 : 9'h001;
			busy <= !busy || pos != 9'h101;
		end
		// Skip the fall before the first bit, it carries nothing
		if (!bitClk && prevClk && busy && pos > 9'h001) begin
			rxFrame <= {rxFrame[254:0], sdataIn};
		end
	end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
	import acl_pkg::*;
;
	localparam logic [19:0] Z = 20'h00000;
	localparam logic [19:0] CMD = {1'b0, 7'h12, 12'h000};
	localparam logic [19:0] REC_L = {18'h2ABCD, 2'b00};
	localparam logic [19:0] REC_R = {18'h1F00F, 2'b00};
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic codecReady = 1'b0;
	acl_rec_t recLeft = '0;
	acl_rec_t recRight = '0;
	logic [5:0] regLookup = 6'h00;
	logic start = 1'b0;
	logic [255:0] txFrame = '0;
	logic [255:0] rxFrame;
	logic [15:0] regLookupData;
	logic sync, sdataOut, bitClk, sdataIn, busy, frameStart, oddIndex, syncFault;
	acl_cmd_t regWr, lastWr;
	acl_pcm_t playLeft, playRight, lastL, lastR;
	int n_errors = 0;
	int checks_done = 0;
	int nWr = 0;
	int nOdd = 0;
	int wrBase = 0;
	int oddBase = 0;

	always #2 core_clk = ~core_clk;

	acl_frame_serdes dut (
		.core_clk(core_clk), .resetn(resetn), .sync(sync), .sdataOut(sdataOut),
		.bitClk(bitClk), .sdataIn(sdataIn), .codecReady(codecReady),
		.recLeft(recLeft), .recRight(recRight), .regLookup(regLookup),
		.regLookupData(regLookupData), .regWr(regWr), .playLeft(playLeft),
		.playRight(playRight), .frameStart(frameStart), .oddIndex(oddIndex),
		.syncFault(syncFault)
	);
	acl_ctrl_model ctrl (
		.core_clk(core_clk), .bitClk(bitClk), .sdataIn(sdataIn), .start(start),
		.txFrame(txFrame), .sync(sync), .sdataOut(sdataOut), .busy(busy),
		.rxFrame(rxFrame)
	);

	// Pulses last one cycle, so catch them as they pass
	always @(posedge core_clk) begin
		if (regWr.valid) begin
			nWr <= nWr + 1;
			lastWr <= regWr;
		end
		if (oddIndex) begin
			nOdd <= nOdd + 1;
		end
		if (playLeft.valid) begin
			lastL <= playLeft;
		end
		if (playRight.valid) begin
			lastR <= playRight;
		end
	end

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One whole frame through the model; both waits are bounded
	task automatic run_frame(input logic [15:0] tag, input logic [19:0] s1, s2, s3, s4);
		int i;
		wrBase = nWr;
		oddBase = nOdd;
		txFrame = {tag, s1, s2, s3, s4, 160'h0};
		start = 1'b1;
		for (i = 0; i < 6000 && !busy; i++) @(negedge core_clk);
		start = 1'b0;
		if (i == 6000) begin
			n_errors++;
			print_verdict();
		end
		for (i = 0; i < 6000 && busy; i++) @(negedge core_clk);
		if (i == 6000) begin
			n_errors++;
			print_verdict();
		end
	endtask

	task automatic check_in(input logic [15:0] tag, input logic [19:0] s1, s2, s3, s4);
		check({4'h0, rxFrame[255:240]}, {4'h0, tag});
		check(rxFrame[239:220], s1);
		check(rxFrame[219:200], s2);
		check(rxFrame[199:180], s3);
		check(rxFrame[179:160], s4);
		check({19'h0, |rxFrame[159:0]}, Z);
	endtask

	task automatic t_unready();
		run_frame(16'h0000, Z, Z, Z, Z);
		check({19'h0, |rxFrame}, Z);
		codecReady = 1'b1;
	endtask

	task automatic t_write();
		run_frame(16'hE000, CMD, {16'hA5C3, 4'h0}, Z, Z);
		check(20'(nWr - wrBase), 20'h00001);
		check({13'h0, lastWr.index}, 20'h00012);
		check({4'h0, lastWr.data}, 20'h0A5C3);
		regLookup = 6'h09;
		repeat (2) @(negedge core_clk);
		check({4'h0, regLookupData}, 20'h0A5C3);
		check_in(16'h8000, Z, Z, Z, Z);
	endtask

	// Slot tags set but frame-valid clear: nothing may be written
	task automatic t_blocked();
		run_frame(16'h6000, CMD, {16'h1234, 4'h0}, Z, Z);
		check(20'(nWr - wrBase), Z);
		check({4'h0, regLookupData}, 20'h0A5C3);
	endtask

	task automatic t_odd();
		run_frame(16'hE000, {1'b0, 7'h13, 12'h000}, {16'h5555, 4'h0}, Z, Z);
		check(20'(nOdd - oddBase), 20'h00001);
		check(20'(nWr - wrBase), Z);
		check({4'h0, regLookupData}, 20'h0A5C3);
	endtask

	// Read with playback and record, answered in the following frame
	task automatic t_read();
		recLeft = {1'b1, 18'h2ABCD};
		recRight = {1'b1, 18'h1F00F};
		run_frame(16'hD800, {1'b1, 7'h12, 12'h000}, Z, 20'hABCDE, 20'h13579);
		check(lastL.sample, 20'hABCDE);
		check(lastR.sample, 20'h13579);
		check_in(16'h9800, Z, Z, REC_L, REC_R);
		run_frame(16'h0000, Z, Z, Z, Z);
		check_in(16'hF800, CMD, 20'hA5C30, REC_L, REC_R);
		check({19'h0, syncFault}, Z);
	endtask

	// Ready seen, so poll the power status register; playback is mono
	task automatic t_power();
		run_frame(16'hD800, {1'b1, 7'h26, 12'h000}, Z, 20'h2468A, 20'h2468A);
		check(lastL.sample, 20'h2468A);
		check(lastR.sample, 20'h2468A);
		check(20'(nWr - wrBase), Z);
		run_frame(16'h0000, Z, Z, Z, Z);
		check_in(16'hE000, {1'b0, 7'h26, 12'h000}, Z, Z, Z);
	endtask

	// Reset in mid-run with a read pending: registers and the read are dropped
	task automatic t_reset();
		run_frame(16'hC000, {1'b1, 7'h12, 12'h000}, Z, Z, Z);
		resetn = 1'b0;
		repeat (16) @(negedge core_clk);
		resetn = 1'b1;
		repeat (2) @(negedge core_clk);
		check({19'h0, syncFault}, Z);
		run_frame(16'h0000, Z, Z, Z, Z);
		check({4'h0, regLookupData}, Z);
		check_in(16'h9800, Z, Z, REC_L, REC_R);
	endtask

	// Bit clock over 2500 core cycles (10 us) must rise 122.88 times on average
	task automatic t_rate();
		int n;
		logic prev;
		n = 0;
		prev = bitClk;
		repeat (2500) begin
			@(negedge core_clk);
			if (bitClk && !prev) begin
				n++;
			end
			prev = bitClk;
		end
		check({19'h0, n == 122 || n == 123}, 20'h00001);
	endtask

	initial begin
		repeat (16) @(negedge core_clk);
		resetn = 1'b1;
		t_unready();
		t_power();
		t_write();
		t_blocked();
		t_odd();
		t_read();
		t_reset();
		t_rate();
		print_verdict();
	end
endmodule
`default_nettype wire
